// file: hdl/bbsr_pkg.sv
// constants, encodings and register map for the buck/boost set-point register bank
`default_nettype none
package bbsr_pkg;
  // register byte addresses (i2c pointer values)
  localparam logic [7:0] BBSR_ADDR_B2_NORM = 8'h35;
  localparam logic [7:0] BBSR_ADDR_B2_STBY = 8'h36;
  localparam logic [7:0] BBSR_ADDR_B2_SLEEP = 8'h37;
  localparam logic [7:0] BBSR_ADDR_B2_MODE = 8'h38;
  localparam logic [7:0] BBSR_ADDR_B2_CONF = 8'h39;
  localparam logic [7:0] BBSR_ADDR_B3_NORM = 8'h3C;
  localparam logic [7:0] BBSR_ADDR_B3_STBY = 8'h3D;
  localparam logic [7:0] BBSR_ADDR_B3_SLEEP = 8'h3E;
  localparam logic [7:0] BBSR_ADDR_B3_MODE = 8'h3F;
  localparam logic [7:0] BBSR_ADDR_B3_CONF = 8'h40;
  localparam logic [7:0] BBSR_ADDR_BST_CTL = 8'h66;

  // default 7-bit i2c device address; value is arbitrary
  localparam logic [6:0] BBSR_I2C_DEV_ADDR = 7'h08;
  // answer to an unmapped pointer
  localparam logic [7:0] BBSR_UNMAPPED_READ = 8'h00;

  // boost control field positions
  localparam int BBSR_BST_VOLT_LSB = 0;
  localparam int BBSR_BST_NMODE_LSB = 2;
  localparam int BBSR_BST_SMODE_LSB = 5;

  // switching-mode encoding shared by normal and standby fields
  typedef enum logic [1:0] {
    BBSR_MODE_OFF = 2'h0,
    BBSR_MODE_PFM = 2'h1,
    BBSR_MODE_AUTO = 2'h2,
    BBSR_MODE_APS = 2'h3
  } bbsr_mode_e;

  // operating state of the device as seen by the converters
  typedef enum logic [1:0] {
    BBSR_PWR_NORMAL = 2'h0,
    BBSR_PWR_STANDBY = 2'h1,
    BBSR_PWR_SLEEP = 2'h2
  } bbsr_pwr_e;

  // reset values
  localparam logic [2:0] BBSR_B2_CODE_RST = 3'h0;
  localparam logic [3:0] BBSR_B3_CODE_RST = 4'h0;
  localparam logic [7:0] BBSR_CFG_RST = 8'h00;
  localparam logic [1:0] BBSR_BST_VOLT_RST = 2'h0;
  localparam bbsr_mode_e BBSR_BST_NMODE_RST = BBSR_MODE_AUTO;
  localparam bbsr_mode_e BBSR_BST_SMODE_RST = BBSR_MODE_AUTO;
  localparam logic [12:0] BBSR_MV_RST = 13'h0000;

  // millivolt decoding constants
  localparam logic [12:0] BBSR_B2_LO_BASE_MV = 13'h05DC; // 1500 mV
  localparam logic [12:0] BBSR_STEP_MV = 13'h0032; // 50 mV
  localparam logic [12:0] BBSR_B3_BASE_MV = 13'h0384; // 900 mV
  localparam logic [12:0] BBSR_BST_BASE_MV = 13'h1388; // 5000 mV
  // high range of the second buck, code 0 first
  localparam logic [12:0] BBSR_B2_HI_MV [8] = '{
    13'h09C4, 13'h0AF0, 13'h0B22, 13'h0BB8, 13'h0C1C, 13'h0C4E, 13'h0C80, 13'h0CE4
  };
endpackage : bbsr_pkg
`default_nettype wire

// file: hdl/bbsr_cfg_if.sv
// register contents passed from the register file to the output selector
`default_nettype none
interface bbsr_cfg_if;
  logic [2:0] b2Norm; // second buck normal code
  logic [2:0] b2Stby; // second buck standby code
  logic [2:0] b2Sleep; // second buck sleep code
  logic [3:0] b3Norm; // third buck normal code
  logic [3:0] b3Stby; // third buck standby code
  logic [3:0] b3Sleep; // third buck sleep code
  logic [1:0] bstVolt; // boost voltage code
  bbsr_pkg::bbsr_mode_e bstNormMode; // boost normal switching mode
  bbsr_pkg::bbsr_mode_e bstStbyMode; // boost standby switching mode
  // register file drives
  modport src (output b2Norm, b2Stby, b2Sleep, b3Norm, b3Stby, b3Sleep, bstVolt,
    bstNormMode, bstStbyMode);
  // selector reads
  modport dst (input b2Norm, b2Stby, b2Sleep, b3Norm, b3Stby, b3Sleep, bstVolt,
    bstNormMode, bstStbyMode);
endinterface : bbsr_cfg_if
`default_nettype wire

// file: hdl/bbsr_output_sel.sv
// picks the state-matching set points and decodes them to millivolt targets
`default_nettype none
module bbsr_output_sel (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register contents
  bbsr_cfg_if.dst cfg,
  // fuses and plant status
  input wire logic buck2HighRangeFuse,
  input wire logic [2:0] boostSequenceSlotFuse,
  input wire bbsr_pkg::bbsr_pwr_e pwrState,
  input wire logic loadHeavy,
  // converter controls
  output logic [2:0] buck2ActiveCode,
  output logic [3:0] buck3ActiveCode,
  output logic [12:0] buck2TargetMv,
  output logic [12:0] buck3TargetMv,
  output logic [12:0] boostTargetMv,
  output logic boostEnable,
  output bbsr_pkg::bbsr_mode_e boostActiveMode
);
  import bbsr_pkg::*;

  // all registered outputs in one word
  typedef struct packed {
    logic [2:0] b2Code;
    logic [3:0] b3Code;
    logic [12:0] b2Mv;
    logic [12:0] b3Mv;
    logic [12:0] bstMv;
    logic bstEn;
    bbsr_mode_e bstMode;
  } bbsr_sel_s;

  bbsr_sel_s cur_reg;
  bbsr_sel_s cur_next;

  // next-value logic
  always_comb begin
    bbsr_mode_e reqMode;
    reqMode = cfg.bstNormMode;
    cur_next = cur_reg;
    // present the code of the current operating state; illegal state acts as normal
    case (pwrState)
      BBSR_PWR_STANDBY: begin
        cur_next.b2Code = cfg.b2Stby;
        cur_next.b3Code = cfg.b3Stby;
        reqMode = cfg.bstStbyMode;
      end
      BBSR_PWR_SLEEP: begin
        cur_next.b2Code = cfg.b2Sleep;
        cur_next.b3Code = cfg.b3Sleep;
        // boost has no sleep field, so it keeps its standby behaviour
        reqMode = cfg.bstStbyMode;
      end
      default: begin
        cur_next.b2Code = cfg.b2Norm;
        cur_next.b3Code = cfg.b3Norm;
        reqMode = cfg.bstNormMode;
      end
    endcase
    // range is fixed by the fuse alone, a bus write only ever picks a code within it
    if (buck2HighRangeFuse) begin
      cur_next.b2Mv = BBSR_B2_HI_MV[cur_next.b2Code];
    end else begin
      cur_next.b2Mv = BBSR_B2_LO_BASE_MV + 13'(cur_next.b2Code) * BBSR_STEP_MV;
    end
    cur_next.b3Mv = BBSR_B3_BASE_MV + 13'(cur_next.b3Code) * BBSR_STEP_MV;
    cur_next.bstMv = BBSR_BST_BASE_MV + 13'(cfg.bstVolt) * BBSR_STEP_MV;
    // boost is left out entirely when its sequence slot is blank
    if (boostSequenceSlotFuse == 3'h0) begin
      reqMode = BBSR_MODE_OFF;
    end
    // auto mode resolves to pfm at light load and aps at heavy load
    if (reqMode == BBSR_MODE_AUTO) begin
      cur_next.bstMode = loadHeavy ? BBSR_MODE_APS : BBSR_MODE_PFM;
    end else begin
      cur_next.bstMode = reqMode;
    end
    cur_next.bstEn = (reqMode != BBSR_MODE_OFF);
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur_reg <= '{b2Code: BBSR_B2_CODE_RST, b3Code: BBSR_B3_CODE_RST, b2Mv: BBSR_MV_RST,
        b3Mv: BBSR_MV_RST, bstMv: BBSR_MV_RST, bstEn: 1'b0, bstMode: BBSR_MODE_OFF};
    end else begin
      cur_reg <= cur_next;
    end
  end

  // outputs straight from flip-flops
  assign buck2ActiveCode = cur_reg.b2Code;
  assign buck3ActiveCode = cur_reg.b3Code;
  assign buck2TargetMv = cur_reg.b2Mv;
  assign buck3TargetMv = cur_reg.b3Mv;
  assign boostTargetMv = cur_reg.bstMv;
  assign boostEnable = cur_reg.bstEn;
  assign boostActiveMode = cur_reg.bstMode;
endmodule : bbsr_output_sel
`default_nettype wire

// file: hdl/buck_boost_setpoint_regs.sv
// i2c slave register bank for second/third buck and boost set points
// Function
// - three independent 3-bit second buck codes
// - low range: 1.500 V plus 50 mV steps
// - high range: fixed eight-entry voltage table
// - range only from fuse, never via bus
// - second buck registers at 0x35 to 0x39
// - third buck: 0.90 V plus 50 mV steps
// - third buck registers at 0x3C to 0x40
// - boost voltage bits 1:0, reset 00
// - boost normal mode bits 3:2 read-only 10
// - boost standby mode bits 6:5, reset 10
// - auto mode picks pfm or aps by load
// - boost sequenced only with non-zero slot fuse
// - sequenced boost starts in automatic mode
`default_nettype none
module buck_boost_setpoint_regs #(
  parameter logic [6:0] I2C_DEV_ADDR = bbsr_pkg::BBSR_I2C_DEV_ADDR
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // i2c slave pins, sda open-drain
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // fuse bits
  input wire logic buck2HighRangeFuse,
  input wire logic [2:0] boostSequenceSlotFuse,
  // operating state and load sense
  input wire bbsr_pkg::bbsr_pwr_e pwrState,
  input wire logic loadHeavy,
  // buck configuration bytes to the converters
  output logic [7:0] buck2ModeCfg,
  output logic [7:0] buck2RampCfg,
  output logic [7:0] buck3ModeCfg,
  output logic [7:0] buck3RampCfg,
  // decoded converter controls
  output logic [2:0] buck2ActiveCode,
  output logic [3:0] buck3ActiveCode,
  output logic [12:0] buck2TargetMv,
  output logic [12:0] buck3TargetMv,
  output logic [12:0] boostTargetMv,
  output logic boostEnable,
  output bbsr_pkg::bbsr_mode_e boostActiveMode
);
  import bbsr_pkg::*;

  // byte-level protocol states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } bbsr_i2c_e;

  // whole module state: protocol engine plus register file
  typedef struct packed {
    bbsr_i2c_e st; // protocol state
    logic sclPrev; // scl one clock ago
    logic sdaPrev; // sda one clock ago
    logic [2:0] bitCnt; // bits seen in current byte
    logic byteDone; // eighth bit sampled
    logic [7:0] shift; // receive / transmit shifter
    logic rw; // 1 when master reads
    logic [7:0] ptr; // register pointer, auto-increments
    logic oe; // pull sda low
    logic mAck; // master acked the last read byte
    logic [2:0] b2Norm; // second buck normal code
    logic [2:0] b2Stby; // second buck standby code
    logic [2:0] b2Sleep; // second buck sleep code
    logic [7:0] b2Mode; // second buck mode byte
    logic [7:0] b2Conf; // second buck ramp/phase/freq/limit byte
    logic [3:0] b3Norm; // third buck normal code
    logic [3:0] b3Stby; // third buck standby code
    logic [3:0] b3Sleep; // third buck sleep code
    logic [7:0] b3Mode; // third buck mode byte
    logic [7:0] b3Conf; // third buck ramp/phase/freq/limit byte
    logic [1:0] bstVolt; // boost voltage code
    bbsr_mode_e bstStby; // boost standby mode
  } bbsr_core_s;

  bbsr_core_s cur_reg;
  bbsr_core_s cur_next;

  // pin events from the previous and current samples
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  assign sclRise = scl && !cur_reg.sclPrev;
  assign sclFall = !scl && cur_reg.sclPrev;
  // sda moving while scl stays high marks start and stop
  assign startSeen = scl && cur_reg.sclPrev && cur_reg.sdaPrev && !sdaIn;
  assign stopSeen = scl && cur_reg.sclPrev && !cur_reg.sdaPrev && sdaIn;

  // read mux; reserved bits read as zero, unmapped pointers read the fixed answer
  function automatic logic [7:0] reg_read(input bbsr_core_s s, input logic [7:0] a);
    logic [7:0] d;
    d = BBSR_UNMAPPED_READ;
    case (a)
      BBSR_ADDR_B2_NORM: d = {5'h00, s.b2Norm};
      BBSR_ADDR_B2_STBY: d = {5'h00, s.b2Stby};
      BBSR_ADDR_B2_SLEEP: d = {5'h00, s.b2Sleep};
      BBSR_ADDR_B2_MODE: d = s.b2Mode;
      BBSR_ADDR_B2_CONF: d = s.b2Conf;
      BBSR_ADDR_B3_NORM: d = {4'h0, s.b3Norm};
      BBSR_ADDR_B3_STBY: d = {4'h0, s.b3Stby};
      BBSR_ADDR_B3_SLEEP: d = {4'h0, s.b3Sleep};
      BBSR_ADDR_B3_MODE: d = s.b3Mode;
      BBSR_ADDR_B3_CONF: d = s.b3Conf;
      BBSR_ADDR_BST_CTL: begin
        d = 8'h00;
        d[BBSR_BST_VOLT_LSB +: 2] = s.bstVolt;
        d[BBSR_BST_NMODE_LSB +: 2] = BBSR_BST_NMODE_RST;
        d[BBSR_BST_SMODE_LSB +: 2] = s.bstStby;
      end
      default: d = BBSR_UNMAPPED_READ;
    endcase
    return d;
  endfunction : reg_read

  // register write; each field is taken independently of its neighbours
  function automatic bbsr_core_s reg_write(input bbsr_core_s s, input logic [7:0] a,
    input logic [7:0] d);
    bbsr_core_s n;
    n = s;
    case (a)
      BBSR_ADDR_B2_NORM: n.b2Norm = d[2:0];
      BBSR_ADDR_B2_STBY: n.b2Stby = d[2:0];
      BBSR_ADDR_B2_SLEEP: n.b2Sleep = d[2:0];
      BBSR_ADDR_B2_MODE: n.b2Mode = d;
      BBSR_ADDR_B2_CONF: n.b2Conf = d;
      BBSR_ADDR_B3_NORM: n.b3Norm = d[3:0];
      BBSR_ADDR_B3_STBY: n.b3Stby = d[3:0];
      BBSR_ADDR_B3_SLEEP: n.b3Sleep = d[3:0];
      BBSR_ADDR_B3_MODE: n.b3Mode = d;
      BBSR_ADDR_B3_CONF: n.b3Conf = d;
      BBSR_ADDR_BST_CTL: begin
        // normal-mode field is read-only, the write to bits 3:2 is dropped
        n.bstVolt = d[BBSR_BST_VOLT_LSB +: 2];
        n.bstStby = bbsr_mode_e'(d[BBSR_BST_SMODE_LSB +: 2]);
      end
      default: n = s; // unmapped writes are acked and ignored
    endcase
    return n;
  endfunction : reg_write

  // next-state logic of the protocol engine and register file
  always_comb begin
    logic [7:0] rd;
    rd = reg_read(cur_reg, cur_reg.ptr);
    cur_next = cur_reg;
    cur_next.sclPrev = scl;
    cur_next.sdaPrev = sdaIn;
    if (startSeen) begin
      // start or repeated start restarts address reception from any state
      cur_next.st = ST_ADDR;
      cur_next.bitCnt = 3'h0;
      cur_next.byteDone = 1'b0;
      cur_next.oe = 1'b0;
    end else if (stopSeen) begin
      // stop always frees the bus
      cur_next.st = ST_IDLE;
      cur_next.oe = 1'b0;
    end else if (sclRise) begin
      // sample on rising scl
      unique case (cur_reg.st)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          cur_next.shift = {cur_reg.shift[6:0], sdaIn};
          cur_next.bitCnt = cur_reg.bitCnt + 3'h1;
          cur_next.byteDone = (cur_reg.bitCnt == 3'h7);
        end
        ST_RDATA: begin
          cur_next.bitCnt = cur_reg.bitCnt + 3'h1;
          cur_next.byteDone = (cur_reg.bitCnt == 3'h7);
        end
        ST_RDATA_ACK: begin
          cur_next.mAck = !sdaIn; // low means the master wants more
        end
        ST_IDLE, ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
          cur_next.mAck = cur_reg.mAck;
        end
      endcase
    end else if (sclFall) begin
      // drive or release sda only while scl is low
      unique case (cur_reg.st)
        ST_ADDR: begin
          if (cur_reg.byteDone) begin
            cur_next.byteDone = 1'b0;
            if (cur_reg.shift[7:1] == I2C_DEV_ADDR) begin
              cur_next.rw = cur_reg.shift[0];
              cur_next.oe = 1'b1;
              cur_next.st = ST_ADDR_ACK;
            end else begin
              // another device is addressed, stay silent until next start
              cur_next.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_RDATA_ACK: begin
          if ((cur_reg.st == ST_ADDR_ACK && cur_reg.rw) ||
              (cur_reg.st == ST_RDATA_ACK && cur_reg.mAck)) begin
            // load the addressed byte and put its msb out at once
            cur_next.shift = rd;
            cur_next.ptr = cur_reg.ptr + 8'h01;
            cur_next.oe = !rd[7];
            cur_next.bitCnt = 3'h0;
            cur_next.st = ST_RDATA;
          end else if (cur_reg.st == ST_ADDR_ACK) begin
            cur_next.oe = 1'b0;
            cur_next.bitCnt = 3'h0;
            cur_next.st = ST_PTR;
          end else begin
            // master nack ends the read, wait for stop or start
            cur_next.oe = 1'b0;
            cur_next.st = ST_IDLE;
          end
        end
        ST_PTR: begin
          if (cur_reg.byteDone) begin
            cur_next.byteDone = 1'b0;
            cur_next.ptr = cur_reg.shift;
            cur_next.oe = 1'b1;
            cur_next.st = ST_PTR_ACK;
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          cur_next.oe = 1'b0;
          cur_next.bitCnt = 3'h0;
          cur_next.st = ST_WDATA;
        end
        ST_WDATA: begin
          if (cur_reg.byteDone) begin
            // commit the byte and step to the next address
            cur_next = reg_write(cur_next, cur_reg.ptr, cur_reg.shift);
            cur_next.byteDone = 1'b0;
            cur_next.ptr = cur_reg.ptr + 8'h01;
            cur_next.oe = 1'b1;
            cur_next.st = ST_WDATA_ACK;
          end
        end
        ST_RDATA: begin
          if (cur_reg.byteDone) begin
            // release for the master's acknowledge bit
            cur_next.byteDone = 1'b0;
            cur_next.oe = 1'b0;
            cur_next.st = ST_RDATA_ACK;
          end else begin
            cur_next.shift = {cur_reg.shift[6:0], 1'b0};
            cur_next.oe = !cur_reg.shift[6];
          end
        end
        ST_IDLE: begin
          cur_next.oe = 1'b0;
        end
      endcase
    end
  end

  // single state register; idle bus assumed high at reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur_reg <= '{st: ST_IDLE, sclPrev: 1'b1, sdaPrev: 1'b1, bitCnt: 3'h0, byteDone: 1'b0,
        shift: 8'h00, rw: 1'b0, ptr: 8'h00, oe: 1'b0, mAck: 1'b0,
        b2Norm: BBSR_B2_CODE_RST, b2Stby: BBSR_B2_CODE_RST, b2Sleep: BBSR_B2_CODE_RST,
        b2Mode: BBSR_CFG_RST, b2Conf: BBSR_CFG_RST,
        b3Norm: BBSR_B3_CODE_RST, b3Stby: BBSR_B3_CODE_RST, b3Sleep: BBSR_B3_CODE_RST,
        b3Mode: BBSR_CFG_RST, b3Conf: BBSR_CFG_RST,
        bstVolt: BBSR_BST_VOLT_RST,
        bstStby: BBSR_BST_SMODE_RST};
    end else begin
      cur_reg <= cur_next;
    end
  end

  // open-drain: only ever pulls low, the enable carries the bit
  assign sdaOut = 1'b0;
  assign sdaOe = cur_reg.oe;

  // configuration bytes handed to the analog side
  assign buck2ModeCfg = cur_reg.b2Mode;
  assign buck2RampCfg = cur_reg.b2Conf;
  assign buck3ModeCfg = cur_reg.b3Mode;
  assign buck3RampCfg = cur_reg.b3Conf;

  // register contents to the selector
  bbsr_cfg_if cfgBus ();

  assign cfgBus.b2Norm = cur_reg.b2Norm;
  assign cfgBus.b2Stby = cur_reg.b2Stby;
  assign cfgBus.b2Sleep = cur_reg.b2Sleep;
  assign cfgBus.b3Norm = cur_reg.b3Norm;
  assign cfgBus.b3Stby = cur_reg.b3Stby;
  assign cfgBus.b3Sleep = cur_reg.b3Sleep;
  assign cfgBus.bstVolt = cur_reg.bstVolt;
  // fixed automatic mode so a sequenced boost starts in auto
  assign cfgBus.bstNormMode = BBSR_BST_NMODE_RST;
  assign cfgBus.bstStbyMode = cur_reg.bstStby;

  // state-matching code selection and voltage decode
  bbsr_output_sel u_sel (
    .clk(clk),
    .rst_b(rst_b),
    .cfg(cfgBus),
    .buck2HighRangeFuse(buck2HighRangeFuse),
    .boostSequenceSlotFuse(boostSequenceSlotFuse),
    .pwrState(pwrState),
    .loadHeavy(loadHeavy),
    .buck2ActiveCode(buck2ActiveCode),
    .buck3ActiveCode(buck3ActiveCode),
    .buck2TargetMv(buck2TargetMv),
    .buck3TargetMv(buck3TargetMv),
    .boostTargetMv(boostTargetMv),
    .boostEnable(boostEnable),
    .boostActiveMode(boostActiveMode)
  );
endmodule : buck_boost_setpoint_regs
`default_nettype wire

// file: dv/bbsr_sva.sv
// assertion checker for the set-point register bank ports
`default_nettype none
module bbsr_sva import bbsr_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // i2c pins
  input wire logic scl,
  input wire logic sdaOe,
  // fuses, state and load
  input wire logic buck2HighRangeFuse,
  input wire logic [2:0] boostSequenceSlotFuse,
  input wire bbsr_pwr_e pwrState,
  input wire logic loadHeavy,
  // decoded outputs
  input wire logic [2:0] buck2ActiveCode,
  input wire logic [3:0] buck3ActiveCode,
  input wire logic [12:0] buck2TargetMv,
  input wire logic [12:0] buck3TargetMv,
  input wire logic boostEnable,
  input wire bbsr_mode_e boostActiveMode
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // one live cycle behind us, so $past sees real inputs
  sequence s_live;
    $past(rst_b);
  endsequence
  // sequenced boost while the device sits in normal state
  sequence s_bst_norm;
    s_live ##0 ($past(boostSequenceSlotFuse) != 3'h0) ##0
      ($past(pwrState) != BBSR_PWR_STANDBY) ##0 ($past(pwrState) != BBSR_PWR_SLEEP);
  endsequence
  // the slave only answers while the host holds scl low
  a_ack_scl_low: assert property ($rose(sdaOe) |-> !scl && !$past(scl))
    else $error("sda pulled while scl high");
  a_oe_steady_high: assert property (scl && $past(scl) |-> $stable(sdaOe))
    else $error("sda changed during scl high");
  a_b2_low_range: assert property (s_live ##0 !$past(buck2HighRangeFuse) |->
    buck2TargetMv == BBSR_B2_LO_BASE_MV + BBSR_STEP_MV * buck2ActiveCode)
    else $error("second buck low range decode wrong");
  a_b2_high_range: assert property (s_live ##0 $past(buck2HighRangeFuse) |->
    buck2TargetMv == BBSR_B2_HI_MV[buck2ActiveCode])
    else $error("second buck high range decode wrong");
  a_b3_linear: assert property (s_live |->
    buck3TargetMv == BBSR_B3_BASE_MV + BBSR_STEP_MV * buck3ActiveCode)
    else $error("third buck decode wrong");
  a_bst_unsequenced: assert property (s_live ##0 ($past(boostSequenceSlotFuse) == 3'h0)
    |-> !boostEnable && boostActiveMode == BBSR_MODE_OFF)
    else $error("boost runs without a slot");
  a_bst_auto_pick: assert property (s_bst_norm |-> boostEnable &&
    boostActiveMode == ($past(loadHeavy) ? BBSR_MODE_APS : BBSR_MODE_PFM))
    else $error("boost auto mode resolved wrongly");
  // no bus write lands while scl stays high, so the code follows the state only
  a_code_holds: assert property (s_live ##0 $past(scl) ##0 $past(scl, 2) ##0
    ($past(pwrState) == $past(pwrState, 2)) |-> $stable(buck2ActiveCode))
    else $error("active code moved without cause");
endmodule : bbsr_sva
bind buck_boost_setpoint_regs bbsr_sva u_sva (.clk(clk), .rst_b(rst_b), .scl(scl),
  .sdaOe(sdaOe), .buck2HighRangeFuse(buck2HighRangeFuse),
  .boostSequenceSlotFuse(boostSequenceSlotFuse), .pwrState(pwrState),
  .loadHeavy(loadHeavy), .buck2ActiveCode(buck2ActiveCode),
  .buck3ActiveCode(buck3ActiveCode), .buck2TargetMv(buck2TargetMv),
  .buck3TargetMv(buck3TargetMv), .boostEnable(boostEnable),
  .boostActiveMode(boostActiveMode));
`default_nettype wire

// file: dv/bbsr_i2c_host.sv
// i2c bus master model that reaches the register bank
`default_nettype none
module bbsr_i2c_host import bbsr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = BBSR_I2C_DEV_ADDR
) (
  // clock
  input wire logic clk,
  // bus pins, sda resolved by the bench with a pull-up
  output logic scl,
  output logic sdaMst,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    scl = 1'b1;
    sdaMst = 1'b1;
  end
  // wait n rising edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one bit slot: 2 clk hold, 2 clk setup, 4 clk high, sampled mid-high
  task automatic bitIo(input logic b, output logic r);
    tick(2);
    sdaMst <= b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl <= 1'b0;
  endtask : bitIo
  // eight bits msb first, then the acknowledge slot
  task automatic byteIo(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
    output logic a);
    for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
    bitIo(ackIn, a);
  endtask : byteIo
  // start or repeated start: sda falls while scl high
  task automatic start();
    tick(2);
    sdaMst <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaMst <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask : start
  // stop: sda rises while scl high
  task automatic stop();
    tick(2);
    sdaMst <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaMst <= 1'b1;
    tick(4);
  endtask : stop
  // single-byte register write; nack flags any missing acknowledge
  task automatic writeReg(input logic [7:0] ptr, input logic [7:0] d, output logic nack);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    byteIo({DEV_ADDR, 1'b0}, 1'b1, q, a0);
    byteIo(ptr, 1'b1, q, a1);
    byteIo(d, 1'b1, q, a2);
    stop();
    nack = a0 | a1 | a2;
  endtask : writeReg
  // pointer write, repeated start, one byte read closed by a nack
  task automatic readReg(input logic [7:0] ptr, output logic [7:0] d, output logic nack);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start();
    byteIo({DEV_ADDR, 1'b0}, 1'b1, q, a0);
    byteIo(ptr, 1'b1, q, a1);
    start();
    byteIo({DEV_ADDR, 1'b1}, 1'b1, q, a2);
    byteIo(8'hFF, 1'b1, d, a3);
    stop();
    nack = a0 | a1 | a2;
  endtask : readReg
endmodule : bbsr_i2c_host
`default_nettype wire

// file: dv/buck_boost_setpoint_regs_bench.sv
// self-checking bench for the set-point register bank
`default_nettype none
module buck_boost_setpoint_regs_bench import bbsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, scl, sdaMst, sda, sdaOut, sdaOe, fuseHi, loadHeavy, boostEnable;
  logic [2:0] slot, buck2ActiveCode;
  logic [3:0] buck3ActiveCode;
  logic [7:0] buck2ModeCfg, buck2RampCfg, buck3ModeCfg, buck3RampCfg;
  logic [12:0] buck2TargetMv, buck3TargetMv, boostTargetMv;
  bbsr_pwr_e pwrState;
  bbsr_mode_e boostActiveMode;
  int err_count = 0, comparisons = 0;
  int hiMv [8] = '{2500, 2800, 2850, 3000, 3100, 3150, 3200, 3300};
  // {third, second} buck codes per state
  logic [6:0] codes [4] = '{7'h7F, 7'h1B, 7'h36, 7'h7F};
  logic [7:0] cfgAddr [4] = '{8'h38, 8'h39, 8'h3F, 8'h40};
  logic [7:0] ssAddr [4] = '{8'h36, 8'h37, 8'h3D, 8'h3E};
  // open-drain wire with pull-up
  assign sda = sdaMst & ~(sdaOe & ~sdaOut);
  buck_boost_setpoint_regs dut (.clk(clk), .rst_b(rst_b), .scl(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .buck2HighRangeFuse(fuseHi),
    .boostSequenceSlotFuse(slot), .pwrState(pwrState), .loadHeavy(loadHeavy),
    .buck2ModeCfg(buck2ModeCfg), .buck2RampCfg(buck2RampCfg), .buck3ModeCfg(buck3ModeCfg),
    .buck3RampCfg(buck3RampCfg), .buck2ActiveCode(buck2ActiveCode),
    .buck3ActiveCode(buck3ActiveCode), .buck2TargetMv(buck2TargetMv),
    .buck3TargetMv(buck3TargetMv), .boostTargetMv(boostTargetMv),
    .boostEnable(boostEnable), .boostActiveMode(boostActiveMode));
  bbsr_i2c_host host (.clk(clk), .scl(scl), .sdaMst(sdaMst), .sda(sda));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // let registered outputs land, then sample off the edge
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // register write, every byte acked
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic n;
    host.writeReg(a, d, n);
    check(16'(n), 16'h0000);
    settle();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic n;
    host.readReg(a, q, n);
    check({7'h00, n, q}, {8'h00, exp});
    settle();
  endtask : rd
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    conclude();
  end
  initial begin
    rst_b = 1'b0;
    fuseHi = 1'b0;
    slot = 3'h1;
    pwrState = BBSR_PWR_NORMAL;
    loadHeavy = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    check(16'(buck3TargetMv), 16'd900);
    check(16'(boostTargetMv), 16'd5000);
    check(16'(boostActiveMode), 16'(BBSR_MODE_PFM));
    rd(8'h66, 8'h48);
    // every code in both fuse ranges
    for (int i = 0; i < 8; i++) begin
      wr(8'h35, 8'(i));
      @(posedge clk);
      fuseHi <= 1'b1;
      settle();
      check(16'(buck2TargetMv), 16'(hiMv[i]));
      @(posedge clk);
      fuseHi <= 1'b0;
      settle();
      check(16'(buck2TargetMv), 16'(1500 + 50 * i));
    end
    // upper bits cannot reach the range selection
    wr(8'h35, 8'hFF);
    rd(8'h35, 8'h07);
    for (int k = 0; k < 4; k++) wr(ssAddr[k], 8'(3 * (k % 2 + 1)));
    wr(8'h3C, 8'hFF);
    rd(8'h3C, 8'h0F);
    // state 3 is taken as normal
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      pwrState <= bbsr_pwr_e'(s);
      settle();
      check(16'({buck3ActiveCode, buck2ActiveCode}), 16'(codes[s]));
    end
    check(16'(buck3TargetMv), 16'd1650);
    for (int k = 0; k < 4; k++) wr(cfgAddr[k], 8'(8'hA0 + k));
    check({buck2ModeCfg, buck2RampCfg}, 16'hA0A1);
    check({buck3ModeCfg, buck3RampCfg}, 16'hA2A3);
    rd(8'h3A, 8'h00);
    // read-only normal mode survives writes of ones
    for (int v = 0; v < 4; v++) begin
      wr(8'h66, 8'(8'hFC | v));
      check(16'(boostTargetMv), 16'(5000 + 50 * v));
      rd(8'h66, 8'(8'h68 | v));
    end
    @(posedge clk);
    loadHeavy <= 1'b1;
    settle();
    check(16'(boostActiveMode), 16'(BBSR_MODE_APS));
    @(posedge clk);
    pwrState <= BBSR_PWR_STANDBY;
    // auto resolves by load, off drops the enable
    for (int m = 0; m < 4; m++) begin
      wr(8'h66, 8'(m << 5));
      check(16'(boostActiveMode), 16'((m == 2) ? 3 : m));
      check(16'(boostEnable), 16'(m != 0));
    end
    @(posedge clk);
    slot <= 3'h0;
    settle();
    check(16'(boostEnable), 16'h0000);
    @(posedge clk);
    slot <= 3'h4;
    settle();
    check(16'(boostEnable), 16'h0001);
    conclude();
  end
endmodule : buck_boost_setpoint_regs_bench
`default_nettype wire
